// [bdpsc_pkg.sv]
// constants and carrier types for the banked dual-port memory port control
//
// Contract
// - selected edge: write_not_read low writes, high reads; master drives controls synchronously.
// - upper lane bits 17:9 gated by upper_byte_enable, lower by lower_byte_enable, low true.
// - lower-only write stores lower byte; upper lane floats and its byte stays.
// - output_drive_enable high floats both lanes at once; read data driven only when low.
// - pipelined latency mode presents read data one cycle after flow-through mode.
// - load strobe low without reload uses external address and captures it for reload.
// - strobe high, count_advance low, no reload: increment and use incremented address.
// - strobe high, count_advance high, no reload: reuse current internal address unchanged.
// - counter_reload low sets counter to last strobe-loaded address, overriding others.
// - reload address not initialised; undefined until first strobe load.
// - counter advances on count_advance low regardless of selects and byte enables.
// - load strobe and reload act regardless of chip selects and byte enables.
// - one counter spans bank and in-bank bits; in-bank carry enters bank field.
// - last in-bank location increments to location zero of next bank.
// - last location of highest bank wraps to location zero of bank zero.
// - same-bank access on both ports is invalid for both ports.
`default_nettype none

package bdpsc_pkg;

    localparam int PORTS      = 2;
    localparam int LANES      = 2;
    localparam int LANE_W     = 9;
    localparam int DATA_W     = LANES * LANE_W;
    localparam int BANK_BITS  = 6;
    localparam int INBANK_BITS = 13;
    localparam int CNT_W      = BANK_BITS + INBANK_BITS;

    localparam int LANE_LO    = 0;
    localparam int LANE_HI    = 1;

    // output_latency_select level that chooses the extra output stage
    localparam logic LAT_PIPELINED = 1'b1;

    localparam logic [LANES-1:0] LANES_IDLE = 2'h0;
    localparam logic             STANDBY_RST = 1'b1;

    typedef struct packed {
        logic                   chip_select_active_low;
        logic                   chip_select_active_high;
        logic                   write_not_read;
        logic                   upper_byte_enable;
        logic                   lower_byte_enable;
        logic                   address_load_strobe;
        logic                   count_advance;
        logic                   counter_reload;
        logic                   output_latency_select;
        logic                   output_drive_enable;
        logic [BANK_BITS-1:0]   bank_select;
        logic [INBANK_BITS-1:0] address;
        logic [DATA_W-1:0]      data_in;
    } bdpsc_req_t;

endpackage : bdpsc_pkg

`default_nettype wire

// [bdpsc_port_ctrl.sv]
// two-port banked memory with per-port access decode, burst counter and output control
`default_nettype none

module bdpsc_port_ctrl #(
    parameter int BANK_BITS   = bdpsc_pkg::BANK_BITS,
    parameter int INBANK_BITS = bdpsc_pkg::INBANK_BITS
) (
    input  wire logic                                           ref_clk,
    input  wire logic                                           rstn,
    input  wire bdpsc_pkg::bdpsc_req_t [bdpsc_pkg::PORTS-1:0]   port_req,
    output logic [bdpsc_pkg::PORTS-1:0][bdpsc_pkg::DATA_W-1:0]  dq_out,
    output logic [bdpsc_pkg::PORTS-1:0][bdpsc_pkg::LANES-1:0]   dq_oe_n,
    output logic [bdpsc_pkg::PORTS-1:0]                         port_standby,
    output logic [bdpsc_pkg::PORTS-1:0]                         bank_conflict
);

    localparam int CW    = BANK_BITS + INBANK_BITS;
    localparam int NP    = bdpsc_pkg::PORTS;
    localparam int NL    = bdpsc_pkg::LANES;
    localparam int DW    = bdpsc_pkg::DATA_W;
    localparam int LW    = bdpsc_pkg::LANE_W;
    localparam int WORDS = 2 ** CW;

    typedef logic [CW-1:0] bdpsc_addr_t;

    ////////////////////////////////////////////////////////////////////////////
    // storage and per-port state

    // every bank of every port shares one array, written in one process
    logic [DW-1:0] mem [WORDS];

    // counter and reload address have no reset, as on the real part
    bdpsc_addr_t             cnt       [NP];
    bdpsc_addr_t             reload    [NP];

    logic [NP-1:0][DW-1:0]   rd_flow;
    logic [NP-1:0][DW-1:0]   rd_pipe;
    logic [NP-1:0][NL-1:0]   lane_flow;
    logic [NP-1:0][NL-1:0]   lane_pipe;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    bdpsc_addr_t             used      [NP];
    logic [NP-1:0]           sel;
    logic [NP-1:0]           wr;
    logic [NP-1:0][NL-1:0]   lane_en;
    logic [NP-1:0][NL-1:0]   wr_lane;
    logic [NP-1:0][NL-1:0]   rd_lane;
    logic [NP-1:0]           active;
    logic                    same_bank;
    logic [NP-1:0][NL-1:0]   lane_now;

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            // only the bank and in-bank bits this build implements take part
            wire bdpsc_addr_t ext_addr = {port_req[p].bank_select[BANK_BITS-1:0],
                                          port_req[p].address[INBANK_BITS-1:0]};
            wire bdpsc_addr_t inc_addr = cnt[p] + bdpsc_addr_t'(1);

            // reload beats strobe, strobe beats advance, else hold
            assign used[p] = !port_req[p].counter_reload      ? reload[p] :
                             !port_req[p].address_load_strobe ? ext_addr  :
                             !port_req[p].count_advance       ? inc_addr  :
                                                                cnt[p];

            assign sel[p] = !port_req[p].chip_select_active_low
                          && port_req[p].chip_select_active_high;
            assign wr[p]  = sel[p] && !port_req[p].write_not_read;

            assign lane_en[p][bdpsc_pkg::LANE_HI] = !port_req[p].upper_byte_enable;
            assign lane_en[p][bdpsc_pkg::LANE_LO] = !port_req[p].lower_byte_enable;

            // blocked lanes neither store nor drive
            assign wr_lane[p] = (wr[p] && !same_bank) ? lane_en[p] : bdpsc_pkg::LANES_IDLE;
            assign rd_lane[p] = (sel[p] && !wr[p]) ? lane_en[p] : bdpsc_pkg::LANES_IDLE;
            assign active[p]  = sel[p] && (lane_en[p] != bdpsc_pkg::LANES_IDLE);

            assign lane_now[p] = (port_req[p].output_latency_select == bdpsc_pkg::LAT_PIPELINED)
                               ? lane_pipe[p] : lane_flow[p];

            // asynchronous output enable overrides the clocked lane state
            assign dq_oe_n[p] = port_req[p].output_drive_enable
                              ? {NL{1'b1}} : ~lane_now[p];
            assign dq_out[p]  = (port_req[p].output_latency_select == bdpsc_pkg::LAT_PIPELINED)
                              ? rd_pipe[p] : rd_flow[p];

            always_ff @(posedge ref_clk) begin
                cnt[p] <= used[p];
                if (port_req[p].counter_reload && !port_req[p].address_load_strobe) begin
                    reload[p] <= ext_addr;
                end
            end

            // conflicting reads return zero; the data is not trustworthy anyway
            always_ff @(posedge ref_clk) begin
                rd_flow[p] <= same_bank ? {DW{1'b0}} : mem[used[p]];
                rd_pipe[p] <= rd_flow[p];
            end

            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    lane_flow[p]     <= bdpsc_pkg::LANES_IDLE;
                    lane_pipe[p]     <= bdpsc_pkg::LANES_IDLE;
                    port_standby[p]  <= bdpsc_pkg::STANDBY_RST;
                    bank_conflict[p] <= 1'b0;
                end else begin
                    lane_flow[p]     <= rd_lane[p];
                    lane_pipe[p]     <= lane_flow[p];
                    port_standby[p]  <= !sel[p];
                    bank_conflict[p] <= same_bank;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // bank conflict: only ports that really move data collide

    assign same_bank = (&active)
        && (used[0][CW-1:INBANK_BITS] == used[1][CW-1:INBANK_BITS]);

    ////////////////////////////////////////////////////////////////////////////
    // byte-lane writes; a lane left out keeps its stored byte

    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NP; i++) begin
            for (int l = 0; l < NL; l++) begin
                if (wr_lane[i][l]) begin
                    mem[used[i]][l*LW +: LW] <= port_req[i].data_in[l*LW +: LW];
                end
            end
        end
    end

endmodule : bdpsc_port_ctrl

`default_nettype wire

// [bdpsc_far_master.sv]
// second-port master model: parked deselected unless clash bit 2 commands a read
`default_nettype none
module bdpsc_far_master (
    input  wire logic [2:0]            clash,
    output var  bdpsc_pkg::bdpsc_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    // bit 2 selects a read with external address, bits 1:0 pick its bank
    always_comb begin
        req = '0;
        {req.chip_select_active_low, req.chip_select_active_high} = {~clash[2], clash[2]};
        {req.write_not_read, req.count_advance, req.counter_reload} = 3'h7;
        req.bank_select = 6'(clash[1:0]);
        req.data_in = 18'h2_5A5A;
    end
endmodule : bdpsc_far_master
`default_nettype wire

// [bdpsc_port_ctrl_props.sv]
// concurrent checks on the port control pins
`default_nettype none
module bdpsc_port_ctrl_props #(
    parameter int BANK_BITS   = bdpsc_pkg::BANK_BITS,
    parameter int INBANK_BITS = bdpsc_pkg::INBANK_BITS
) (
    input wire logic                                ref_clk,
    input wire logic                                rstn,
    input wire bdpsc_pkg::bdpsc_req_t [1:0]         port_req,
    input wire logic [1:0][bdpsc_pkg::DATA_W-1:0]   dq_out,
    input wire logic [1:0][1:0]                     dq_oe_n,
    input wire logic [1:0]                          port_standby,
    input wire logic [1:0]                          bank_conflict
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire bdpsc_pkg::bdpsc_req_t p0 = port_req[0];
    wire bdpsc_pkg::bdpsc_req_t p1 = port_req[1];
    wire s0 = p0.chip_select_active_high & ~p0.chip_select_active_low;
    wire s1 = p1.chip_select_active_high & ~p1.chip_select_active_low;
    wire both = s0 & s1 & ~(p0.upper_byte_enable & p0.lower_byte_enable)
        & ~(p1.upper_byte_enable & p1.lower_byte_enable);
    wire [1:0] lanes = p0.write_not_read ? {p0.upper_byte_enable, p0.lower_byte_enable} : 2'b11;
    wire pipe = p0.output_latency_select == bdpsc_pkg::LAT_PIPELINED;
    // bank inputs only say where the ports go when both take the external address
    wire ext = ~p0.address_load_strobe & ~p1.address_load_strobe
        & p0.counter_reload & p1.counter_reload;
    wire same = p0.bank_select[BANK_BITS-1:0] == p1.bank_select[BANK_BITS-1:0];
    a_ode_floats: assert property (p0.output_drive_enable |-> dq_oe_n[0] == 2'b11)
        else $error("lanes driven while disabled");
    a_lane_gate: assert property (s0 && !s1 && !pipe |=> pipe || p0.output_drive_enable
        || dq_oe_n[0] == $past(lanes)) else $error("lane enable wrong");
    a_desel_float: assert property (!s0 && !pipe |=> pipe || dq_oe_n[0] == 2'b11)
        else $error("deselected port drives");
    a_pipe_late: assert property (s0 && !s1 && pipe && lanes == 2'b00 ##1 pipe
        |=> p0.output_drive_enable || dq_oe_n[0] == 2'b00) else $error("pipelined read late");
    a_standby_on: assert property (!s0 |=> port_standby[0]) else $error("no standby");
    a_standby_off: assert property (s0 |=> !port_standby[0]) else $error("stuck standby");
    a_bank_clash: assert property (both && ext && same |=> bank_conflict == 2'b11)
        else $error("clash not flagged");
    a_no_clash: assert property (ext && !same |=> bank_conflict == 2'b00)
        else $error("false clash");
    c_pipe_read: cover property (s0 && pipe && lanes == 2'b00);
    c_clash: cover property (both && ext && same);
    c_ode: cover property (s0 && p0.output_drive_enable);
endmodule : bdpsc_port_ctrl_props
bind bdpsc_port_ctrl bdpsc_port_ctrl_props #(.BANK_BITS(BANK_BITS), .INBANK_BITS(INBANK_BITS))
    bdpsc_port_ctrl_props_i (.ref_clk, .rstn, .port_req, .dq_out, .dq_oe_n, .port_standby,
    .bank_conflict);
`default_nettype wire

// [test_banked_dual_port_sram_port_control.sv]
// self-checking bench: byte lanes, burst counter, output float and bank clash
`default_nettype none
module test_banked_dual_port_sram_port_control;
    timeunit 1ns;
    timeprecision 1ps;
    // flag order: select, write_not_read, upper, lower, strobe, advance, reload, latency
    localparam logic [7:0] WR = 8'h86, WRLO = 8'hA6, RD = 8'hC6, RDLO = 8'hE6, ADV = 8'hCA,
        HOLD = 8'hCE, RPT = 8'hCC, NOEN = 8'hF6, IDLE = 8'h7E, DLOAD = 8'h76, DADV = 8'h7A;
    localparam logic [17:0] D1 = 18'h2_AB55, D2 = 18'h1_3C0F, D3 = 18'h0_F00D, D4 = 18'h3_1234;
    logic ref_clk = 1'b0, rstn = 1'b0, ode = 1'b0;
    logic [2:0] clash = 3'h0;
    int miscompares = 0, compares = 0, cycles = 0;
    bdpsc_pkg::bdpsc_req_t req0 = '0, req1;
    logic [1:0][17:0] dq_out;
    logic [1:0][1:0] dq_oe_n;
    logic [1:0] port_standby, bank_conflict;
    bdpsc_port_ctrl #(.BANK_BITS(2), .INBANK_BITS(4)) bdpsc_port_ctrl_i (.ref_clk, .rstn,
        .port_req({req1, req0}), .dq_out, .dq_oe_n, .port_standby, .bank_conflict);
    bdpsc_far_master bdpsc_far_master_i (.clash, .req(req1));
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cycles > 3000) begin
        miscompares++;
        report_and_stop();
    end
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic op(input logic [7:0] f, input logic [5:0] a, input logic [17:0] d);
        req0 = {~f[7], f, ode, 4'h0, a[5:4], 9'h000, a[3:0], d};
        @(negedge ref_clk);
    endtask : op
    // lanes that float are masked out of the data compare
    task automatic rd(input logic [7:0] f, input logic [5:0] a, input logic [17:0] d,
                      input logic [1:0] oe);
        logic [17:0] m;
        m = {{9{oe[1]}}, {9{oe[0]}}};
        op(f, a, 18'h0_0000);
        // flow data stands right after the read edge, pipelined data one edge later
        repeat (int'(f[0])) op(IDLE | 8'(f[0]), a, 18'h0_0000);
        check({dq_oe_n[0], dq_out[0] | m}, {oe, d | m});
    endtask : rd
    task automatic t_lanes();
        op(WR, 6'h05, D1);
        op(WRLO, 6'h05, D2);
        rd(RD, 6'h05, {D1[17:9], D2[8:0]}, 2'b00);
        rd(RDLO, 6'h05, {D1[17:9], D2[8:0]}, 2'b10);
        rd(RD | 8'h01, 6'h05, {D1[17:9], D2[8:0]}, 2'b00);
        ode = 1'b1;
        rd(RD, 6'h05, D1, 2'b11);
        ode = 1'b0;
        rd(NOEN, 6'h05, D1, 2'b11);
    endtask : t_lanes
    task automatic t_burst();
        op(WR, 6'h0F, D1);
        op(WR, 6'h10, D2);
        op(WR, 6'h3F, D3);
        op(WR, 6'h00, D4);
        rd(RD, 6'h0F, D1, 2'b00);
        rd(ADV, 6'h2A, D2, 2'b00);
        rd(HOLD, 6'h2A, D2, 2'b00);
        rd(RPT, 6'h2A, D1, 2'b00);
        op(DLOAD, 6'h3F, D4);
        check(20'(port_standby[0]), 20'h0_0001);
        rd(HOLD, 6'h2A, D3, 2'b00);
        op(DADV, 6'h2A, D4);
        rd(HOLD, 6'h2A, D4, 2'b00);
    endtask : t_burst
    task automatic t_clash();
        clash = 3'h5;
        op(RD, 6'h10, D1);
        check(20'(bank_conflict), 20'h0_0003);
        check({2'b00, dq_out[0]}, 20'h0_0000);
        check({dq_oe_n[1], dq_out[1]}, 20'h0_0000);
        // a clashing write must leave the stored word alone
        op(WR, 6'h10, D4);
        clash = 3'h6;
        rd(RD, 6'h10, D2, 2'b00);
        check(20'(bank_conflict), 20'h0_0000);
    endtask : t_clash
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (2) @(negedge ref_clk);
        rstn = 1'b1;
        t_lanes();
        t_burst();
        t_clash();
        report_and_stop();
    end
endmodule : test_banked_dual_port_sram_port_control
`default_nettype wire
